//--- dv/iecs_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module iecs_core_model
   import iecs_pkg::*;
(
   input wire logic clk, // Clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic allowTake, // Core may stop at a boundary.
   input wire logic retCmd, // Bench asks for a return.
   input wire logic ctxLoad, // Overwrite live context.
   input wire iecs_pkg::iecs_ctx_t ctxIn, // New live context.
   input wire logic stackPush, // Push pulse.
   input wire logic [14:0] stackPushPc, // Pushed address.
   input wire logic loadVector, // Vector pulse.
   input wire logic [14:0] vectorAddr, // Vector.
   input wire logic stackPop, // Pop pulse.
   input wire logic restoreValid, // Restore pulse.
   input wire iecs_pkg::iecs_ctx_t restoreCtx, // Restored context.
   output var iecs_pkg::iecs_ctx_t coreCtx, // Live context.
   output logic [14:0] corePc, // Program counter.
   output logic coreBoundary, // Boundary level.
   output logic returnFromIrq, // Return pulse.
   output logic inIsr // Service routine running.
);
   // ==========
   // Core sequencer.
   logic [14:0] stackTop_r;
   // A slow core simply withholds the boundary.
   assign coreBoundary = allowTake;
   // One stack level suffices: entry clears the global enable, so entries never nest.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         coreCtx <= '0;
         corePc <= 15'h0000;
         stackTop_r <= 15'h0000;
         returnFromIrq <= 1'b0;
         inIsr <= 1'b0;
      end else begin
         corePc <= corePc + 15'h0001;
         returnFromIrq <= retCmd & inIsr;
         if (ctxLoad) coreCtx <= ctxIn;
         if (stackPush) stackTop_r <= stackPushPc;
         if (loadVector) begin
            corePc <= vectorAddr;
            inIsr <= 1'b1;
         end
         if (stackPop) begin
            corePc <= stackTop_r;
            inIsr <= 1'b0;
         end
         if (restoreValid) coreCtx <= restoreCtx;
      end
   end
endmodule
`default_nettype wire

//--- dv/iecs_irq_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module iecs_irq_ctrl_checker
   import iecs_pkg::*;
(
   input wire logic clk, // Clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic [11:0] regAddr, // Register address.
   input wire logic regRe, // Read strobe.
   input wire logic [7:0] regRdata, // Read data.
   input wire logic [7:0] perPinChangeFlags, // Per-pin flags.
   input wire iecs_pkg::iecs_ctx_t coreCtx, // Live context.
   input wire logic [14:0] corePc, // Core address.
   input wire logic coreBoundary, // Core boundary.
   input wire logic returnFromIrq, // Return pulse.
   input wire logic irqRequest, // Request.
   input wire logic flushPrefetch, // Flush pulse.
   input wire logic stackPush, // Push pulse.
   input wire logic [14:0] stackPushPc, // Pushed address.
   input wire logic loadVector, // Vector pulse.
   input wire logic [14:0] vectorAddr, // Vector.
   input wire logic stackPop, // Pop pulse.
   input wire logic restoreValid, // Restore pulse.
   input wire iecs_pkg::iecs_ctx_t restoreCtx // Restored context.
);
   // ==========
   // Entry and return sequencing.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic [1:0] liveBits;
   // The two status bits that are never shadowed must come back from the live core.
   assign liveBits = coreCtx.status[4:3];
   sequence s_take;
      irqRequest && coreBoundary && !returnFromIrq;
   endsequence
   sequence s_entry;
      flushPrefetch && stackPush && loadVector ##1 !flushPrefetch && !stackPush && !loadVector;
   endsequence
   a_entry_steps: assert property (s_take |=> s_entry)
      else $error("entry pulses wrong after a take");
   a_push_addr: assert property (s_take |=> stackPushPc == $past(corePc))
      else $error("pushed address differs from core address");
   a_take_blocks: assert property (s_take |=> !irqRequest)
      else $error("request still up after a take");
   a_vector_fixed: assert property (vectorAddr == IRQ_VECTOR)
      else $error("vector address wrong");
   a_push_cause: assert property (stackPush |-> $past(irqRequest) && $past(coreBoundary) && !$past(returnFromIrq))
      else $error("push without a take");
   a_return_steps: assert property (returnFromIrq |=> stackPop && restoreValid)
      else $error("return pulses missing");
   a_restore_live: assert property (restoreValid |-> restoreCtx.status[4:3] == $past(liveBits))
      else $error("excluded status bits not taken from live core");
   a_summary_view: assert property ($past(regRe) && $past(regAddr) == OFF_IRQ_CONTROL
      |-> regRdata[0] == |$past(perPinChangeFlags))
      else $error("summary flag differs from per-pin flags");
   a_two_unused: assert property ($past(regRe) && $past(regAddr) == OFF_PERIPH_EN_TWO
      |-> regRdata[2:0] == 3'h0)
      else $error("unused enable bits read nonzero");
endmodule
bind iecs_irq_ctrl iecs_irq_ctrl_checker iecs_irq_ctrl_checker_i (.clk, .rst_n, .regAddr, .regRe, .regRdata,
   .perPinChangeFlags, .coreCtx, .corePc, .coreBoundary, .returnFromIrq, .irqRequest, .flushPrefetch,
   .stackPush, .stackPushPc, .loadVector, .vectorAddr, .stackPop, .restoreValid, .restoreCtx);
`default_nettype wire

//--- dv/iecs_irq_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module iecs_irq_ctrl_tb;
   import iecs_pkg::*;
   typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] e;} iecs_row_t;
   logic clk = 1'b0, rst_n = 1'b0, regWe = 1'b0, regRe = 1'b0, timer0Ovf = 1'b0, extPinEdge = 1'b0;
   logic allowTake = 1'b0, retCmd = 1'b0, ctxLoad = 1'b0;
   logic irqRequest, flushPrefetch, stackPush, loadVector, stackPop, restoreValid, coreBoundary, returnFromIrq, inIsr;
   logic [11:0] regAddr = 12'h000;
   logic [7:0] regWdata = 8'h00, perPinChangeFlags = 8'h00, periphFlagsOne = 8'h00, periphFlagsTwo = 8'h00, regRdata;
   logic [14:0] corePc, stackPushPc, vectorAddr;
   iecs_ctx_t coreCtx, restoreCtx, ctxIn = '0;
   int n_mismatch = 0, checks_done = 0, k;
   // Write, read-back pairs; control bit 0 and unused bits drop their writes.
   iecs_row_t rows [13] = '{'{OFF_IRQ_CONTROL, 8'h7f, 8'h7e}, '{OFF_IRQ_CONTROL, 8'h00, 8'h00},
      '{OFF_PERIPH_EN_ONE, 8'ha5, 8'ha5}, '{OFF_PERIPH_EN_ONE, 8'h5a, 8'h5a}, '{OFF_PERIPH_EN_TWO, 8'hff, 8'hf8},
      '{SHADOW_BANK_BASE, 8'h3c, 8'h3c}, '{12'hfe5, 8'hff, 8'he7}, '{12'hfe6, 8'hff, 8'h1f},
      '{12'hfe7, 8'hff, 8'h7f}, '{12'hfeb, 8'h81, 8'h81}, '{12'h123, 8'hff, 8'h00},
      '{OFF_PERIPH_EN_ONE, 8'h00, 8'h00}, '{OFF_PERIPH_EN_TWO, 8'h00, 8'h00}};

   always #12.5 clk = ~clk;

   iecs_irq_ctrl #(.HAS_COMP_TWO(1'b1), .REG_ADDR_W(12)) iecs_irq_ctrl_i (.clk, .rst_n, .regAddr, .regWdata,
      .regWe, .regRe, .regRdata, .timer0Ovf, .extPinEdge, .perPinChangeFlags, .periphFlagsOne, .periphFlagsTwo,
      .coreCtx, .corePc, .coreBoundary, .returnFromIrq, .irqRequest, .flushPrefetch, .stackPush, .stackPushPc,
      .loadVector, .vectorAddr, .stackPop, .restoreValid, .restoreCtx);
   iecs_core_model iecs_core_model_i (.clk, .rst_n, .allowTake, .retCmd, .ctxLoad, .ctxIn, .stackPush,
      .stackPushPc, .loadVector, .vectorAddr, .stackPop, .restoreValid, .restoreCtx, .coreCtx, .corePc,
      .coreBoundary, .returnFromIrq, .inIsr);

   // ==========
   // Bus cycles and comparison.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWe <= 1'b1;
      @(posedge clk);
      regWe <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so it is sampled there.
   task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRe <= 1'b1;
      @(posedge clk);
      regRe <= 1'b0;
      #1 chk(regRdata, e);
   endtask
   task automatic ev(input logic t, input logic e);
      @(posedge clk);
      timer0Ovf <= t;
      extPinEdge <= e;
      @(posedge clk);
      timer0Ovf <= 1'b0;
      extPinEdge <= 1'b0;
   endtask
   task automatic loadCtx(input iecs_ctx_t c);
      @(posedge clk);
      ctxIn <= c;
      ctxLoad <= 1'b1;
      @(posedge clk);
      ctxLoad <= 1'b0;
   endtask
   task automatic resetChk();
      rdChk(OFF_IRQ_CONTROL, 8'h00);
      rdChk(OFF_PERIPH_EN_ONE, 8'h00);
      rdChk(OFF_PERIPH_EN_TWO, 8'h00);
   endtask
   task automatic test_done();
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ==========
   // Main sequence.
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      resetChk();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rdChk(rows[i].a, rows[i].e);
      end
      // Flags latch with every enable off; the summary follows the per-pin flags only.
      ev(1'b1, 1'b1);
      perPinChangeFlags <= 8'h10;
      rdChk(OFF_IRQ_CONTROL, 8'h07);
      chk(irqRequest, 1'b0);
      wr(OFF_IRQ_CONTROL, 8'h00);
      rdChk(OFF_IRQ_CONTROL, 8'h01);
      @(posedge clk) perPinChangeFlags <= 8'h00;
      rdChk(OFF_IRQ_CONTROL, 8'h00);
      // Each core source stays pending while global enable is off, then requests.
      for (k = 0; k < 3; k++) begin
         wr(OFF_IRQ_CONTROL, 8'h20 >> k);
         ev(k == 0, k == 1);
         if (k == 2) perPinChangeFlags <= 8'h01;
         @(posedge clk);
         #1 chk(irqRequest, 1'b0);
         wr(OFF_IRQ_CONTROL, 8'h80 | (8'h20 >> k) | (8'h04 >> k));
         #1 chk(irqRequest, 1'b1);
         wr(OFF_IRQ_CONTROL, 8'h00);
         perPinChangeFlags <= 8'h00;
      end
      // Peripheral sources need the gate as well as their own enable.
      wr(OFF_PERIPH_EN_ONE, 8'h01);
      wr(OFF_PERIPH_EN_TWO, 8'h40);
      wr(OFF_IRQ_CONTROL, 8'h80);
      @(posedge clk) periphFlagsTwo <= 8'h40;
      #1 chk(irqRequest, 1'b0);
      wr(OFF_IRQ_CONTROL, 8'hc0);
      #1 chk(irqRequest, 1'b1);
      @(posedge clk) periphFlagsTwo <= 8'h00;
      periphFlagsOne <= 8'h02;
      #1 chk(irqRequest, 1'b0);
      @(posedge clk) periphFlagsOne <= 8'h01;
      #1 chk(irqRequest, 1'b1);
      @(posedge clk) periphFlagsOne <= 8'h00;
      // Full take and return with the context edited in between.
      wr(OFF_IRQ_CONTROL, 8'h20);
      loadCtx('{acc: 8'h11, status: 8'hff, bank: 5'h1b, pcHigh: 7'h2a, fsr0: 16'h1234, fsr1: 16'h5678});
      ev(1'b1, 1'b0);
      allowTake <= 1'b1;
      wr(OFF_IRQ_CONTROL, 8'ha4);
      #1;
      for (k = 0; k < 10 && loadVector !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      chk(flushPrefetch & stackPush & loadVector, 1'b1);
      chk(vectorAddr, IRQ_VECTOR);
      @(posedge clk) allowTake <= 1'b0;
      rdChk(OFF_IRQ_CONTROL, 8'h24);
      rdChk(12'hfe5, 8'he7);
      rdChk(12'hfe7, 8'h2a);
      rdChk(12'hfe9, 8'h12);
      loadCtx('{acc: 8'h99, status: 8'h00, bank: 5'h00, pcHigh: 7'h00, fsr0: 16'h0000, fsr1: 16'h0000});
      wr(SHADOW_BANK_BASE, 8'h55);
      wr(OFF_IRQ_CONTROL, 8'h20);
      @(posedge clk) retCmd <= 1'b1;
      @(posedge clk) retCmd <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(coreCtx.acc, 8'h55);
      chk(coreCtx.status, 8'he7);
      chk(coreCtx.fsr1, 16'h5678);
      chk(inIsr, 1'b0);
      rdChk(OFF_IRQ_CONTROL, 8'ha0);
      // A reset in mid-run clears every enable again.
      wr(OFF_PERIPH_EN_ONE, 8'hff);
      @(posedge clk) rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      resetChk();
      test_done();
   end

   // The whole run takes under two hundred cycles; 4000 means a hang.
   initial begin
      #100000;
      n_mismatch++;
      test_done();
   end
endmodule
`default_nettype wire

//--- rtl/iecs_irq_ctrl.sv
// Functional notes
// - Taken interrupt pushes return PC.
// - Entry copies context into shadows.
// - Return reloads context from shadows.
// - Shadows read/write in bank 31.
// - Flags set regardless of enables.
// - Global enable bit 7 gates all.
// - Peripheral gate bit 6 gates peripherals.
// - Timer0 overflow: enable 5, flag 2.
// - External pin: enable 4, flag 1.
// - Pin change: enable 3, summary 0.
// - Summary read-only, clears with per-pin flags.
// - First peripheral enable register layout.
// - Second register bits 7-3, 2-0 zero.
// - Comparator two enable only on variant.
// - All control and enables reset zero.
// - Take: flush, clear global, push, vector.
// - Return pops, restores, sets global enable.
// - Blocked interrupts stay pending in flags.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module iecs_irq_ctrl
   import iecs_pkg::*;
#(
   parameter bit HAS_COMP_TWO = 1'b1, // Second comparator present on this variant.
   parameter int REG_ADDR_W = 12 // Register address width.
)
(
   input wire logic clk, // Instruction clock, 40 MHz.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic [11:0] regAddr, // Register address.
   input wire logic [7:0] regWdata, // Register write data.
   input wire logic regWe, // Write strobe, one cycle.
   input wire logic regRe, // Read strobe, one cycle.
   output logic [7:0] regRdata, // Read data, valid the cycle after the strobe.
   input wire logic timer0Ovf, // Timer0 overflow event pulse.
   input wire logic extPinEdge, // Valid edge seen on the external pin.
   input wire logic [7:0] perPinChangeFlags, // Per-pin change flags held outside.
   input wire logic [7:0] periphFlagsOne, // First peripheral flag register.
   input wire logic [7:0] periphFlagsTwo, // Second peripheral flag register.
   input wire iecs_pkg::iecs_ctx_t coreCtx, // Live core context.
   input wire logic [14:0] corePc, // Return address of the interrupted flow.
   input wire logic coreBoundary, // Core can accept an interrupt this cycle.
   input wire logic returnFromIrq, // Core executes return_from_irq.
   output logic irqRequest, // Combined interrupt request to the core.
   output logic flushPrefetch, // Flush prefetched instruction, one cycle.
   output logic stackPush, // Push stackPushPc, one cycle.
   output logic [14:0] stackPushPc, // Return address to push.
   output logic loadVector, // Load vectorAddr into PC, one cycle.
   output logic [14:0] vectorAddr, // Interrupt vector.
   output logic stackPop, // Pop return address, one cycle.
   output logic restoreValid, // Restore context, one cycle.
   output iecs_pkg::iecs_ctx_t restoreCtx // Context to reload.
);
   import iecs_pkg::*;

   // ======================================================================
   // Elaboration checks.
   // ======================================================================
   // Decode and the shadow window assume the fixed twelve-bit map.
   if (REG_ADDR_W != ADDR_W) begin : g_bad_addr_w
      $error("iecs_irq_ctrl: register address width must be 12");
   end

   // ======================================================================
   // State.
   // ======================================================================
   logic globalEnable_r;
   logic periphGate_r;
   logic timer0Enable_r;
   logic extPinEnable_r;
   logic pinChangeEnable_r;
   logic timer0Flag_r;
   logic extPinFlag_r;
   logic [7:0] periphEnOne_r;
   logic [7:0] periphEnTwo_r;
   logic [7:0] rdata_r;
   logic flush_r;
   logic push_r;
   logic [14:0] pushPc_r;
   logic vector_r;
   logic pop_r;
   logic restore_r;
   iecs_ctx_t restoreCtx_r;

   logic globalEnable_nxt;
   logic timer0Flag_nxt;
   logic extPinFlag_nxt;
   logic [7:0] rdata_nxt;

   // ======================================================================
   // Address decode.
   // ======================================================================
   wire logic hitControl = (regAddr == OFF_IRQ_CONTROL);
   wire logic hitEnOne = (regAddr == OFF_PERIPH_EN_ONE);
   wire logic hitEnTwo = (regAddr == OFF_PERIPH_EN_TWO);
   wire logic [11:0] shadowOffset = regAddr - SHADOW_BANK_BASE;
   wire logic hitShadow = (regAddr >= SHADOW_BANK_BASE) && (shadowOffset <= {9'h000, SHADOW_COUNT});
   wire logic [2:0] shadowIdx = shadowOffset[2:0];
   wire logic wrControl = regWe && hitControl;
   wire logic wrShadow = regWe && hitShadow;

   // Implemented bits of the second enable register depend on the variant.
   wire logic [7:0] enTwoMask = HAS_COMP_TWO ? PERIPH_TWO_MASK : (PERIPH_TWO_MASK & ~(8'h01 << COMP2_BIT));

   // ======================================================================
   // Request combination.
   // ======================================================================
   // Summary is a pure reduction, so it cannot be written and drops only once every pin flag is clear.
   wire logic pinChangeSummary = |perPinChangeFlags;
   wire logic coreHit = (timer0Enable_r && timer0Flag_r)
      || (extPinEnable_r && extPinFlag_r)
      || (pinChangeEnable_r && pinChangeSummary);
   wire logic periphHit = |(periphEnOne_r & periphFlagsOne) || |(periphEnTwo_r & enTwoMask & periphFlagsTwo);
   // Flags stay set while blocked, so a request reappears as soon as the gates open again.
   assign irqRequest = globalEnable_r && (coreHit || (periphGate_r && periphHit));

   // A return in the same cycle takes priority; the core cannot do both at one boundary.
   wire logic takeNow = irqRequest && coreBoundary && !returnFromIrq;

   wire iecs_ctx_t shadowCtx;

   // ======================================================================
   // Shadow bank.
   // ======================================================================
   iecs_shadow_bank u_shadow (
      .clk(clk),
      .rst_n(rst_n),
      .save(takeNow),
      .liveCtx(coreCtx),
      .wrEn(wrShadow),
      .wrIdx(shadowIdx),
      .wrData(regWdata),
      .shadowCtx(shadowCtx)
   );

   // ======================================================================
   // Global enable: hardware entry and return override a software write.
   // ======================================================================
   always_comb begin
      globalEnable_nxt = globalEnable_r;
      if (wrControl) begin
         globalEnable_nxt = regWdata[GLOBAL_EN_BIT];
      end
      if (takeNow) begin
         globalEnable_nxt = 1'b0;
      end else if (returnFromIrq) begin
         globalEnable_nxt = 1'b1;
      end
   end

   // ======================================================================
   // Core flags: an event in the cycle of a software clear still sets.
   // ======================================================================
   always_comb begin
      timer0Flag_nxt = timer0Flag_r;
      extPinFlag_nxt = extPinFlag_r;
      if (wrControl) begin
         timer0Flag_nxt = regWdata[T0IF_BIT];
         extPinFlag_nxt = regWdata[EXTIF_BIT];
      end
      if (timer0Ovf) begin
         timer0Flag_nxt = 1'b1;
      end
      if (extPinEdge) begin
         extPinFlag_nxt = 1'b1;
      end
   end

   // ======================================================================
   // Read mux: control bits, enables, shadows; unmapped reads as zero.
   // ======================================================================
   wire logic [7:0] controlView = {globalEnable_r, periphGate_r, timer0Enable_r, extPinEnable_r,
      pinChangeEnable_r, timer0Flag_r, extPinFlag_r, pinChangeSummary};

   always_comb begin
      rdata_nxt = 8'h00;
      if (regRe) begin
         if (hitControl) begin
            rdata_nxt = controlView;
         end else if (hitEnOne) begin
            rdata_nxt = periphEnOne_r;
         end else if (hitEnTwo) begin
            rdata_nxt = periphEnTwo_r & enTwoMask;
         end else if (hitShadow) begin
            rdata_nxt = iecs_ctx_byte(shadowCtx, shadowIdx);
         end
      end
   end

   // ======================================================================
   // Control and enable registers.
   // ======================================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         globalEnable_r <= CONTROL_RESET[GLOBAL_EN_BIT];
         periphGate_r <= CONTROL_RESET[PERIPH_GATE_BIT];
         timer0Enable_r <= CONTROL_RESET[T0IE_BIT];
         extPinEnable_r <= CONTROL_RESET[EXTIE_BIT];
         pinChangeEnable_r <= CONTROL_RESET[PCIE_BIT];
         timer0Flag_r <= CONTROL_RESET[T0IF_BIT];
         extPinFlag_r <= CONTROL_RESET[EXTIF_BIT];
         periphEnOne_r <= PERIPH_EN_RESET;
         periphEnTwo_r <= PERIPH_EN_RESET;
      end else begin
         globalEnable_r <= globalEnable_nxt;
         timer0Flag_r <= timer0Flag_nxt;
         extPinFlag_r <= extPinFlag_nxt;
         if (wrControl) begin
            periphGate_r <= regWdata[PERIPH_GATE_BIT];
            timer0Enable_r <= regWdata[T0IE_BIT];
            extPinEnable_r <= regWdata[EXTIE_BIT];
            pinChangeEnable_r <= regWdata[PCIE_BIT];
         end
         if (regWe && hitEnOne) begin
            periphEnOne_r <= regWdata;
         end
         if (regWe && hitEnTwo) begin
            periphEnTwo_r <= regWdata & enTwoMask;
         end
      end
   end

   // ======================================================================
   // Read data register.
   // ======================================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ======================================================================
   // Entry sequence: all entry pulses appear together one cycle after the take.
   // ======================================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flush_r <= 1'b0;
         push_r <= 1'b0;
         pushPc_r <= 15'h0000;
         vector_r <= 1'b0;
      end else begin
         flush_r <= takeNow;
         push_r <= takeNow;
         vector_r <= takeNow;
         if (takeNow) begin
            pushPc_r <= corePc;
         end
      end
   end

   // ======================================================================
   // Return sequence: pop and restore one cycle after the return strobe.
   // ======================================================================
   // Watchdog and power-down bits are never shadowed, so the live ones pass through untouched.
   iecs_ctx_t restoreSel;
   always_comb begin
      restoreSel = shadowCtx;
      restoreSel.status = (shadowCtx.status & STATUS_SAVE_MASK) | (coreCtx.status & ~STATUS_SAVE_MASK);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pop_r <= 1'b0;
         restore_r <= 1'b0;
         restoreCtx_r <= '0;
      end else begin
         pop_r <= returnFromIrq;
         restore_r <= returnFromIrq;
         if (returnFromIrq) begin
            restoreCtx_r <= restoreSel;
         end
      end
   end

   // ======================================================================
   // Output drive.
   // ======================================================================
   assign regRdata = rdata_r;
   assign flushPrefetch = flush_r;
   assign stackPush = push_r;
   assign stackPushPc = pushPc_r;
   assign loadVector = vector_r;
   assign vectorAddr = IRQ_VECTOR;
   assign stackPop = pop_r;
   assign restoreValid = restore_r;
   assign restoreCtx = restoreCtx_r;

endmodule
`default_nettype wire

//--- rtl/iecs_pkg.sv
`default_nettype none
package iecs_pkg;

   // ======================================================================
   // Register map: control and enable registers, then the shadow bank.
   // ======================================================================
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_IRQ_CONTROL = 12'h00b;
   localparam logic [11:0] OFF_PERIPH_EN_ONE = 12'h091;
   localparam logic [11:0] OFF_PERIPH_EN_TWO = 12'h092;
   localparam logic [11:0] SHADOW_BANK_BASE = 12'hfe4;
   localparam logic [2:0] SHADOW_COUNT = 3'h7;
   localparam logic [2:0] SH_ACC = 3'h0;
   localparam logic [2:0] SH_STATUS = 3'h1;
   localparam logic [2:0] SH_BANK = 3'h2;
   localparam logic [2:0] SH_PC_HIGH = 3'h3;
   localparam logic [2:0] SH_FSR0_LO = 3'h4;
   localparam logic [2:0] SH_FSR0_HI = 3'h5;
   localparam logic [2:0] SH_FSR1_LO = 3'h6;
   localparam logic [2:0] SH_FSR1_HI = 3'h7;

   // ======================================================================
   // Field positions and reset values.
   // ======================================================================
   localparam int GLOBAL_EN_BIT = 7;
   localparam int PERIPH_GATE_BIT = 6;
   localparam int T0IE_BIT = 5;
   localparam int EXTIE_BIT = 4;
   localparam int PCIE_BIT = 3;
   localparam int T0IF_BIT = 2;
   localparam int EXTIF_BIT = 1;
   localparam int PCIF_BIT = 0;
   localparam int COMP2_BIT = 6;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] PERIPH_EN_RESET = 8'h00;
   localparam logic [7:0] PERIPH_TWO_MASK = 8'hf8;
   localparam logic [7:0] STATUS_SAVE_MASK = 8'he7;
   localparam int PC_W = 15;
   localparam logic [14:0] IRQ_VECTOR = 15'h0004;

   // ======================================================================
   // Context carried between the core and the shadow bank.
   // ======================================================================
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] status;
      logic [4:0] bank;
      logic [6:0] pcHigh;
      logic [15:0] fsr0;
      logic [15:0] fsr1;
   } iecs_ctx_t;

   // Byte view of one context field, used by the shadow read path.
   function automatic logic [7:0] iecs_ctx_byte(input iecs_ctx_t c, input logic [2:0] idx);
      case (idx)
         SH_ACC: iecs_ctx_byte = c.acc;
         SH_STATUS: iecs_ctx_byte = c.status;
         SH_BANK: iecs_ctx_byte = {3'h0, c.bank};
         SH_PC_HIGH: iecs_ctx_byte = {1'h0, c.pcHigh};
         SH_FSR0_LO: iecs_ctx_byte = c.fsr0[7:0];
         SH_FSR0_HI: iecs_ctx_byte = c.fsr0[15:8];
         SH_FSR1_LO: iecs_ctx_byte = c.fsr1[7:0];
         default: iecs_ctx_byte = c.fsr1[15:8];
      endcase
   endfunction

endpackage
`default_nettype wire

//--- rtl/iecs_shadow_bank.sv
`timescale 1ns/10ps
`default_nettype none
module iecs_shadow_bank
   import iecs_pkg::*;
(
   input wire logic clk, // Instruction clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic save, // Capture the live context this cycle.
   input wire iecs_pkg::iecs_ctx_t liveCtx, // Live core context.
   input wire logic wrEn, // Software write to one shadow byte.
   input wire logic [2:0] wrIdx, // Shadow byte index.
   input wire logic [7:0] wrData, // Software write data.
   output iecs_pkg::iecs_ctx_t shadowCtx // Stored shadow context.
);
   import iecs_pkg::*;

   iecs_ctx_t shadow_r;
   iecs_ctx_t shadow_nxt;
   iecs_ctx_t edited;

   // ======================================================================
   // Software edit of one byte; the edited copy is what a return restores.
   // ======================================================================
   always_comb begin
      edited = shadow_r;
      case (wrIdx)
         SH_ACC: edited.acc = wrData;
         SH_STATUS: edited.status = wrData & STATUS_SAVE_MASK;
         SH_BANK: edited.bank = wrData[4:0];
         SH_PC_HIGH: edited.pcHigh = wrData[6:0];
         SH_FSR0_LO: edited.fsr0[7:0] = wrData;
         SH_FSR0_HI: edited.fsr0[15:8] = wrData;
         SH_FSR1_LO: edited.fsr1[7:0] = wrData;
         default: edited.fsr1[15:8] = wrData;
      endcase
   end

   // Entry capture beats a software edit in the same cycle, since the core has just committed.
   always_comb begin
      shadow_nxt = shadow_r;
      if (save) begin
         shadow_nxt = liveCtx;
         shadow_nxt.status = liveCtx.status & STATUS_SAVE_MASK;
      end else if (wrEn) begin
         shadow_nxt = edited;
      end
   end

   // Shadow storage.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shadow_r <= '0;
      end else begin
         shadow_r <= shadow_nxt;
      end
   end

   assign shadowCtx = shadow_r;

endmodule
`default_nettype wire
